// ---- inc/rrs_pkg.sv ----
package rrs_pkg;

  // Byte offsets on the APB slave
  localparam logic [11:0] RRS_OFF_INSTR = 12'h000;
  localparam logic [11:0] RRS_OFF_ACC = 12'h004;
  localparam logic [11:0] RRS_OFF_STATUS = 12'h008;
  localparam logic [11:0] RRS_OFF_PC = 12'h00c;
  localparam logic [11:0] RRS_OFF_LEVEL = 12'h010;
  localparam logic [11:0] RRS_OFF_CYCLES = 12'h014;
  localparam logic [11:0] RRS_OFF_STACK = 12'h040;
  localparam logic [11:0] RRS_OFF_FILE = 12'h100;

  // Instruction word fields
  localparam int RRS_OP_LSB = 0;
  localparam int RRS_OP_W = 3;
  localparam int RRS_DEST_BIT = 3;
  localparam int RRS_FADDR_LSB = 4;
  localparam int RRS_FADDR_W = 6;
  localparam int RRS_LIT_LSB = 16;

  // Status register bits
  localparam int RRS_ST_C = 0;
  localparam int RRS_ST_DC = 1;
  localparam int RRS_ST_Z = 2;
  localparam int RRS_ST_GIE = 3;
  localparam int RRS_ST_BUSY = 4;
  localparam int RRS_ST_UFLOW = 5;

  // Values after reset
  localparam logic [7:0] RRS_ACC_RST = 8'h00;
  localparam logic [31:0] RRS_INSTR_RST = 32'h0000_0000;
  localparam logic [15:0] RRS_CYCLES_RST = 16'h0000;

  // Instruction cycles per instruction
  localparam logic [1:0] RRS_CYC_SHORT = 2'h1;
  localparam logic [1:0] RRS_CYC_RET = 2'h2;

  typedef enum logic [2:0] {
    RRS_OP_IDLE = 3'h0,
    RRS_OP_RETLIT = 3'h1,
    RRS_OP_RETINT = 3'h2,
    RRS_OP_RET = 3'h3,
    RRS_OP_ROTL = 3'h4,
    RRS_OP_ROTR = 3'h5,
    RRS_OP_SUB = 3'h6
  } rrs_op_t;

  typedef enum logic [1:0] {
    RRS_S_IDLE = 2'h0,
    RRS_S_EXEC = 2'h1,
    RRS_S_HOLD = 2'h3
  } rrs_state_t;

endpackage

// ---- hw/rrs_alu.sv ----
`timescale 1ns/1ps
module rrs_alu (
  input wire rrs_pkg::rrs_op_t op,
  input wire logic [7:0] r,
  input wire logic [7:0] acc,
  input wire logic c_in,
  output logic [7:0] res,
  output logic c_out,
  output logic dc_out,
  output logic z_out
);
  logic [8:0] sum;
  logic [4:0] nib;

  // Borrow is carried inverted: carry set means no borrow
  assign sum = {1'b0, r} + {1'b0, ~acc} + {8'h00, c_in}; // RL9 RL10
  assign nib = {1'b0, r[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, c_in}; // RL12

  always_comb begin
    res = r;
    c_out = c_in;
    case (op)
      rrs_pkg::RRS_OP_ROTL: begin
        res = {r[6:0], c_in}; // RL6
        c_out = r[7]; // RL6
      end
      rrs_pkg::RRS_OP_ROTR: begin
        res = {c_in, r[7:1]}; // RL7
        c_out = r[0]; // RL7
      end
      rrs_pkg::RRS_OP_SUB: begin
        res = sum[7:0]; // RL9
        c_out = sum[8]; // RL10
      end
      default: begin
        res = r;
        c_out = c_in;
      end
    endcase
    dc_out = nib[4]; // RL12
    z_out = (sum[7:0] == 8'h00); // RL10
  end
endmodule

// ---- hw/rrs_file.sv ----
`timescale 1ns/1ps
module rrs_file (
  input wire logic pclk,
  input wire logic we,
  input wire logic [5:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [5:0] raddr_a,
  output logic [7:0] rdata_a,
  input wire logic [5:0] raddr_b,
  output logic [7:0] rdata_b
);
  // Data storage only, so no reset; contents start undefined
  logic [7:0] mem [0:63]; // RL11

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];
endmodule

// ---- hw/rrs_core.sv ----
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Contract
// [RL1] Idle instruction only advances program counter by one, one cycle.
// [RL2] Return with literal loads literal to accumulator, pops, sets enable.
// [RL3] Every return takes top stack entry into PC, then level drops by one; on an empty stack the code loads entry 0 and keeps level at zero.
// [RL4] Interrupt return pops, sets global enable, two cycles, flags kept.
// [RL5] Subroutine return pops only, enable and flags kept, two cycles.
// [RL6] Left rotate: carry to bit 0, bits 6..0 up, bit 7 to carry.
// [RL7] Right rotate: carry to bit 7, bits 7..1 down, bit 0 to carry.
// [RL8] Destination bit 0 writes accumulator, 1 writes the file register.
// [RL9] Subtract computes file plus inverted accumulator plus carry.
// [RL10] Carry is inverted borrow; zero flag set on zero result.
// [RL11] File operand is a six-bit direct address, registers 0 to 63.
// [RL12] Digit carry is carry out of bit 3, inverted borrow.
module rrs_core #(
  parameter int PCW = 10,
  parameter int DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy
);
  localparam int LVW = $clog2(DEPTH + 1);

  generate
    if (PCW < 1 || PCW > 16 || DEPTH < 1 || DEPTH > 16) begin : g_chk
      $error("rrs_core: PCW must be 1..16 and DEPTH 1..16");
    end
  endgenerate

  typedef struct packed {
    rrs_pkg::rrs_state_t st;
    logic [1:0] left;
    logic [31:0] instr;
    logic [7:0] acc;
    logic c;
    logic dc;
    logic z;
    logic global_interrupt_enable;
    logic uflow;
    logic [PCW-1:0] pc;
    logic [LVW-1:0] level;
    logic [DEPTH-1:0][PCW-1:0] stack;
    logic [15:0] cycles;
    logic busy;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rrs_core_state_t;

  rrs_core_state_t s_reg;
  rrs_core_state_t s_next;

  rrs_pkg::rrs_op_t op;
  logic dest;
  logic [5:0] faddr;
  logic [7:0] lit;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic [7:0] file_exec;
  logic [7:0] file_bus;
  logic fw_en;
  logic [5:0] fw_addr;
  logic [7:0] fw_data;

  logic aligned;
  logic hit_instr;
  logic hit_acc;
  logic hit_status;
  logic hit_pc;
  logic hit_level;
  logic hit_cycles;
  logic hit_stack;
  logic hit_file;
  logic mapped;
  logic [3:0] sidx;
  logic [31:0] rdata;
  logic [31:0] status_word;
  logic decide;
  logic finish;

  assign op = rrs_pkg::rrs_op_t'(s_reg.instr[rrs_pkg::RRS_OP_LSB +:
                                             rrs_pkg::RRS_OP_W]);
  assign dest = s_reg.instr[rrs_pkg::RRS_DEST_BIT];
  assign faddr = s_reg.instr[rrs_pkg::RRS_FADDR_LSB +:
                             rrs_pkg::RRS_FADDR_W]; // RL11
  assign lit = s_reg.instr[rrs_pkg::RRS_LIT_LSB +: 8];

  // Address decode, word aligned only
  assign aligned = (paddr[1:0] == 2'h0);
  assign hit_instr = (paddr == rrs_pkg::RRS_OFF_INSTR);
  assign hit_acc = (paddr == rrs_pkg::RRS_OFF_ACC);
  assign hit_status = (paddr == rrs_pkg::RRS_OFF_STATUS);
  assign hit_pc = (paddr == rrs_pkg::RRS_OFF_PC);
  assign hit_level = (paddr == rrs_pkg::RRS_OFF_LEVEL);
  assign hit_cycles = (paddr == rrs_pkg::RRS_OFF_CYCLES);
  assign sidx = paddr[5:2];
  assign hit_stack = aligned &&
                     (paddr[11:6] == rrs_pkg::RRS_OFF_STACK[11:6]) &&
                     (32'(sidx) < DEPTH);
  assign hit_file = aligned &&
                    (paddr[11:8] == rrs_pkg::RRS_OFF_FILE[11:8]);
  assign mapped = hit_instr | hit_acc | hit_status | hit_pc |
                  hit_level | hit_cycles | hit_stack | hit_file;

  // First access cycle with busy low decides, the next edge completes the transfer
  assign decide = psel & penable & ~s_reg.pready & ~s_reg.busy;
  assign finish = psel & penable & s_reg.pready;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[rrs_pkg::RRS_ST_C] = s_reg.c;
    status_word[rrs_pkg::RRS_ST_DC] = s_reg.dc;
    status_word[rrs_pkg::RRS_ST_Z] = s_reg.z;
    status_word[rrs_pkg::RRS_ST_GIE] = s_reg.global_interrupt_enable;
    status_word[rrs_pkg::RRS_ST_BUSY] = s_reg.busy;
    status_word[rrs_pkg::RRS_ST_UFLOW] = s_reg.uflow;
  end

  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_instr) begin
      rdata = s_reg.instr;
    end else if (hit_acc) begin
      rdata = {24'h00_0000, s_reg.acc};
    end else if (hit_status) begin
      rdata = status_word;
    end else if (hit_pc) begin
      rdata = 32'(s_reg.pc);
    end else if (hit_level) begin
      rdata = 32'(s_reg.level);
    end else if (hit_cycles) begin
      rdata = {16'h0000, s_reg.cycles};
    end else if (hit_stack) begin
      rdata = 32'(s_reg.stack[sidx]);
    end else if (hit_file) begin
      rdata = {24'h00_0000, file_bus};
    end
  end

  rrs_alu u_alu (
    .op(op),
    .r(file_exec),
    .acc(s_reg.acc),
    .c_in(s_reg.c),
    .res(alu_res),
    .c_out(alu_c),
    .dc_out(alu_dc),
    .z_out(alu_z)
  );

  rrs_file u_file (
    .pclk(pclk),
    .we(fw_en),
    .waddr(fw_addr),
    .wdata(fw_data),
    .raddr_a(faddr),
    .rdata_a(file_exec),
    .raddr_b(paddr[7:2]),
    .rdata_b(file_bus)
  );

  always_comb begin
    logic [LVW-1:0] top;
    top = s_reg.level - 1'b1;
    s_next = s_reg;
    fw_en = 1'b0;
    fw_addr = paddr[7:2];
    fw_data = pwdata[7:0];
    s_next.pready = 1'b0;

    if (decide) begin
      s_next.pready = 1'b1;
      s_next.pslverr = ~(aligned & mapped);
      s_next.prdata = rdata;
    end

    // Writes land only at the edge that completes the transfer
    if (finish && pwrite && !s_reg.pslverr) begin
      if (hit_instr) begin
        s_next.instr = pwdata;
        s_next.st = rrs_pkg::RRS_S_EXEC;
        s_next.busy = 1'b1;
      end
      if (hit_acc) begin
        s_next.acc = pwdata[7:0];
      end
      if (hit_status) begin
        s_next.c = pwdata[rrs_pkg::RRS_ST_C];
        s_next.dc = pwdata[rrs_pkg::RRS_ST_DC];
        s_next.z = pwdata[rrs_pkg::RRS_ST_Z];
        s_next.global_interrupt_enable = pwdata[rrs_pkg::RRS_ST_GIE];
        if (pwdata[rrs_pkg::RRS_ST_UFLOW]) begin
          s_next.uflow = 1'b0;
        end
      end
      if (hit_pc) begin
        s_next.pc = pwdata[PCW-1:0];
      end
      // Level saturates so a pop never indexes past the stack
      if (hit_level) begin
        if (32'(pwdata[LVW-1:0]) > DEPTH) begin
          s_next.level = LVW'(DEPTH);
        end else begin
          s_next.level = pwdata[LVW-1:0];
        end
      end
      if (hit_stack) begin
        s_next.stack[sidx] = pwdata[PCW-1:0];
      end
      if (hit_file) begin
        fw_en = 1'b1;
      end
    end

    case (s_reg.st)
      rrs_pkg::RRS_S_IDLE: begin
        s_next.busy = s_next.busy;
      end
      rrs_pkg::RRS_S_EXEC: begin
        s_next.cycles = s_reg.cycles + 16'h0001;
        s_next.left = rrs_pkg::RRS_CYC_SHORT;
        case (op)
          rrs_pkg::RRS_OP_RETLIT, rrs_pkg::RRS_OP_RETINT,
          rrs_pkg::RRS_OP_RET: begin
            s_next.left = rrs_pkg::RRS_CYC_RET; // RL4 RL5
            // Empty stack: flag it and keep the level at zero
            if (s_reg.level == '0) begin
              s_next.uflow = 1'b1;
              s_next.pc = s_reg.stack[0];
            end else begin
              s_next.pc = s_reg.stack[top]; // RL3
              s_next.level = top; // RL3
            end
            if (op == rrs_pkg::RRS_OP_RETLIT) begin
              s_next.acc = lit; // RL2
            end
            if (op != rrs_pkg::RRS_OP_RET) begin
              s_next.global_interrupt_enable = 1'b1; // RL2 RL4
            end
          end
          rrs_pkg::RRS_OP_ROTL, rrs_pkg::RRS_OP_ROTR,
          rrs_pkg::RRS_OP_SUB: begin
            s_next.pc = s_reg.pc + 1'b1;
            s_next.c = alu_c; // RL6 RL7
            if (op == rrs_pkg::RRS_OP_SUB) begin
              s_next.dc = alu_dc; // RL12
              s_next.z = alu_z; // RL10
            end
            if (dest) begin
              fw_en = 1'b1; // RL8
              fw_addr = faddr;
              fw_data = alu_res;
            end else begin
              s_next.acc = alu_res; // RL8
            end
          end
          default: begin
            s_next.pc = s_reg.pc + 1'b1; // RL1
          end
        endcase
        if (s_next.left == rrs_pkg::RRS_CYC_SHORT) begin
          s_next.st = rrs_pkg::RRS_S_IDLE; // RL1
          s_next.busy = 1'b0;
        end else begin
          s_next.st = rrs_pkg::RRS_S_HOLD;
          s_next.left = s_next.left - 2'h1;
        end
      end
      rrs_pkg::RRS_S_HOLD: begin
        // Second cycle of a return; only the cycle count advances
        s_next.cycles = s_reg.cycles + 16'h0001;
        s_next.left = s_reg.left - 2'h1;
        if (s_reg.left == rrs_pkg::RRS_CYC_SHORT) begin
          s_next.st = rrs_pkg::RRS_S_IDLE; // RL4 RL5
          s_next.busy = 1'b0;
        end
      end
      default: begin
        s_next.st = rrs_pkg::RRS_S_IDLE;
        s_next.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.st <= rrs_pkg::RRS_S_IDLE;
      s_reg.instr <= rrs_pkg::RRS_INSTR_RST;
      s_reg.acc <= rrs_pkg::RRS_ACC_RST;
      s_reg.cycles <= rrs_pkg::RRS_CYCLES_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign busy = s_reg.busy;
endmodule

// ---- bench/rrs_checker.sv ----
`timescale 1ns/1ps
module rrs_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic busy
);
  logic go;
  logic [2:0] op;
  // Launch is the completing edge of an instruction write
  assign go = psel && penable && pwrite && pready && paddr == 12'h000;
  assign op = pwdata[2:0];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_idle;
    go && op == 3'h0 |=> busy ##1 !busy;
  endproperty
  a_idle: assert property (p_idle) else $error("idle length");
  property p_rotl;
    go && op == 3'h4 |=> busy && !pready ##1 !busy;
  endproperty
  a_rotl: assert property (p_rotl) else $error("rotl length");
  property p_rotr;
    go && op == 3'h5 |-> ##1 $rose(busy) ##1 $fell(busy);
  endproperty
  a_rotr: assert property (p_rotr) else $error("rotr length");
  property p_sub;
    go && op == 3'h6 |=> busy ##1 (!busy && !pready);
  endproperty
  a_sub: assert property (p_sub) else $error("sub length");
  property p_retlit;
    go && op == 3'h1 |=> busy[*2] ##1 !busy;
  endproperty
  a_retlit: assert property (p_retlit) else $error("retlit length");
  property p_retint;
    go && op == 3'h2 |=> busy ##1 busy ##1 $fell(busy);
  endproperty
  a_retint: assert property (p_retint) else $error("retint length");
  property p_ret;
    go && op == 3'h3 |=> (busy && !pready)[*2] ##1 !busy;
  endproperty
  a_ret: assert property (p_ret) else $error("ret length");
  property p_stall;
    psel && penable && busy |=> !pready;
  endproperty
  a_stall: assert property (p_stall) else $error("answer while busy");
endmodule
bind rrs_core rrs_checker rrs_checker_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .busy(busy));

// ---- bench/tb_rrs_core.sv ----
`timescale 1ns/1ps
module tb_rrs_core;
  localparam logic [11:0] o_acc = rrs_pkg::RRS_OFF_ACC;
  localparam logic [11:0] o_st = rrs_pkg::RRS_OFF_STATUS;
  localparam logic [11:0] o_pc = rrs_pkg::RRS_OFF_PC;
  localparam logic [11:0] o_lv = rrs_pkg::RRS_OFF_LEVEL;
  localparam logic [11:0] o_sk = rrs_pkg::RRS_OFF_STACK;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic busy;
  logic er;
  logic chain = 1'b0;
  logic [31:0] sd = 32'h5c;
  int error_cnt = 0;
  int check_count = 0;
  rrs_core rrs_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));
  initial begin
    forever #10 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    sd = sd ^ (sd << 13);
    sd = sd ^ (sd >> 17);
    sd = sd ^ (sd << 5);
    return sd;
  endfunction
  // Result is {z, dc, c, value}; f holds {z, dc, c} before
  function automatic logic [10:0] model(input logic [2:0] op,
      input logic [7:0] r, input logic [7:0] a, input logic [2:0] f);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, r} + {1'b0, ~a} + {8'h0, f[0]};
    h = {1'b0, r[3:0]} + {1'b0, ~a[3:0]} + {4'h0, f[0]};
    if (op == 3'h4) return {f[2:1], r[7], r[6:0], f[0]};
    if (op == 3'h5) return {f[2:1], r[0], f[0], r[7:1]};
    return {s[7:0] == 8'h0, h[4], s[8], s[7:0]};
  endfunction
  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic bad(input logic [31:0] g, input logic [31:0] x);
    error_cnt++;
    $display("unexpected at %0t: got %h want %h", $time, g, x);
  endtask
  // Extra idle edge at the end keeps back-to-back calls race free
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 60);
    rd = prdata;
    er = pslverr;
    penable <= 1'b0;
    if (n >= 60) bad(32'h0, 32'h1);
    // Chained call keeps psel so the next setup follows at once
    if (!chain) begin
      psel <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check_count++;
    if (rd !== x || er !== 1'b0) bad(rd, x);
  endtask
  task automatic alu(input logic [2:0] op, input logic d,
      input logic [5:0] fa, input logic [7:0] r, input logic [7:0] a,
      input logic [2:0] f);
    logic [10:0] m;
    logic [11:0] fr;
    m = model(op, r, a, f);
    fr = rrs_pkg::RRS_OFF_FILE + {4'h0, fa, 2'b00};
    wr(fr, {24'h0, r});
    wr(o_acc, {24'h0, a});
    wr(o_st, {29'h0, f});
    wr(12'h000, {22'h0, fa, d, op});
    chk(o_acc, {24'h0, d ? a : m[7:0]});
    chk(fr, {24'h0, d ? m[7:0] : r});
    chk(o_st, {29'h0, m[10:8]});
  endtask
  initial begin
    #1000000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    logic [31:0] p;
    logic [31:0] a;
    logic [2:0] op;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) chk(12'(4 * i), 32'h0);
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, i ? 12'h006 : 12'h0f0, 32'h0);
      check_count++;
      if (er !== 1'b1 || rd !== 32'h0) bad(rd, 32'h0);
      p = rnd() & 32'h3fe;
      a = rnd() & 32'hff;
      wr(o_pc, p);
      wr(o_acc, a);
      wr(o_st, 32'h5);
      wr(12'h000, i ? 32'h7 : 32'h0);
      chk(o_pc, p + 32'h1);
      chk(o_acc, a);
      chk(o_st, 32'h5);
    end
    for (int k = 1; k < 4; k++) begin
      p = rnd() & 32'h3ff;
      a = rnd() & 32'hff;
      wr(o_sk, 32'h15);
      wr(o_sk + 12'h004, p);
      wr(o_lv, 32'h2);
      wr(o_acc, 32'h0);
      wr(o_st, 32'h7);
      // Read straight after the return lands in its busy window
      chain = 1'b1;
      wr(12'h000, {8'h0, a[7:0], 13'h0, k[2:0]});
      chain = 1'b0;
      chk(o_pc, p);
      chk(o_lv, 32'h1);
      chk(o_acc, k == 1 ? a : 32'h0);
      chk(o_st, k == 3 ? 32'h7 : 32'hf);
      wr(12'h000, 32'h3);
      chk(o_pc, 32'h15);
      chk(o_lv, 32'h0);
    end
    // Pop from an empty stack: entry 0 reused, underflow flagged
    wr(12'h000, 32'h3);
    chk(o_pc, 32'h15);
    chk(o_lv, 32'h0);
    chk(o_st, 32'h27);
    wr(o_st, 32'h20);
    chk(o_st, 32'h0);
    alu(3'h4, 1'b1, 6'h00, 8'ha5, 8'h00, 3'h0);
    alu(3'h5, 1'b1, 6'h3f, 8'ha5, 8'h00, 3'h0);
    alu(3'h6, 1'b1, 6'h01, 8'h05, 8'h06, 3'h0);
    alu(3'h6, 1'b1, 6'h02, 8'h05, 8'h06, 3'h1);
    alu(3'h6, 1'b1, 6'h03, 8'h06, 8'h05, 3'h0);
    alu(3'h6, 1'b0, 6'h04, 8'h06, 8'h05, 3'h1);
    repeat (40) begin
      op = 3'h4 + 3'(rnd() % 3);
      p = rnd();
      a = rnd();
      alu(op, p[0], p[6:1], p[15:8], a[7:0], a[10:8]);
    end
    report_and_stop();
  end
endmodule
